// ===== rtl/mfsc_params.svh
`ifndef MFSC_PARAMS_SVH
`define MFSC_PARAMS_SVH
// register offsets (byte-wide registers, one address each)
`define MFSC_OFS_TMR_H 8'h00
`define MFSC_OFS_TMR_L 8'h01
`define MFSC_OFS_PER_H 8'h02
`define MFSC_OFS_PER_L 8'h03
`define MFSC_OFS_TCON 8'h04
`define MFSC_OFS_BUF1_H 8'h05
`define MFSC_OFS_BUF1_L 8'h06
`define MFSC_OFS_BUF2_H 8'h07
`define MFSC_OFS_BUF2_L 8'h08
`define MFSC_OFS_BUF3_H 8'h09
`define MFSC_OFS_BUF3_L 8'h0A
`define MFSC_OFS_CAP1_CON 8'h0B
`define MFSC_OFS_CAP2_CON 8'h0C
`define MFSC_OFS_CAP3_CON 8'h0D
`define MFSC_OFS_QDEC_CON 8'h0E
`define MFSC_OFS_IRQ_FLAGS 8'h0F
`define MFSC_OFS_IRQ_EN 8'h10
`define MFSC_OFS_SLEEP 8'h11
// field positions
`define MFSC_TCON_ON_BIT 0
`define MFSC_CCON_REN_BIT 6
`define MFSC_QCON_MODE_LSB 2
`define MFSC_QCON_DIR_BIT 5
`define MFSC_FLAG_CH1_BIT 1
`define MFSC_FLAG_CH2_BIT 2
`define MFSC_FLAG_CH3_BIT 3
// reset values, irq mask and prescaler maximum
`define MFSC_RST_BYTE 8'h00
`define MFSC_RST_PERIOD 16'hFFFF
`define MFSC_RST_WORD 16'h0000
`define MFSC_IRQ_MASK 8'h0E
`define MFSC_PS_MAX 2'h3
`endif

// ===== rtl/mfsc_pkg.sv
package mfsc_pkg;
	// capture event selection, low nibble of a channel control register
	typedef enum logic [3:0] {
		MFSC_CAP_OFF = 4'h0,
		MFSC_CAP_RISE = 4'h1,
		MFSC_CAP_FALL = 4'h2,
		MFSC_CAP_EDGE = 4'h3,
		MFSC_CAP_RISE4 = 4'h4
	} mfsc_cap_mode_t;
	// power state, gray along awake -> asleep -> waking; waking -> awake flips both bits
	typedef enum logic [1:0] {
		MFSC_AWAKE = 2'b00,
		MFSC_ASLEEP = 2'b01,
		MFSC_WAKING = 2'b11
	} mfsc_pwr_t;
endpackage

// ===== rtl/mfsc_core.sv
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "mfsc_params.svh"
module mfsc_core
	import mfsc_pkg::*;
#(
	parameter int VEL_PERIOD = 256
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [2:0] cap_in,
	input wire logic sleep_req,
	output logic asleep,
	output logic wake,
	output logic irq
);
	logic [15:0] tmr, period, buf1, buf2, buf3, pos, vel_cnt;
	logic [7:0] tcon, qcon, flags, irq_en;
	logic [7:0] ccon [3];
	logic [2:0] cap_q, ev, pend;
	logic [1:0] ps [3];
	logic [1:0] qd_q;
	logic dir;
	logic [7:0] vel_div;
	mfsc_pwr_t pwr, next_pwr;

	wire qdec_on = qcon[`MFSC_QCON_MODE_LSB +: 3] != 3'b000;
	wire run = clk_en && pwr == MFSC_AWAKE;
	wire tmr_on = tcon[`MFSC_TCON_ON_BIT];
	wire wr_flags = wr && addr == `MFSC_OFS_IRQ_FLAGS;
	wire [7:0] flag_hit = flags & irq_en & `MFSC_IRQ_MASK;
	// quadrature: A on cap_in[1], B on cap_in[2]
	wire [1:0] qd_now = cap_in[2:1];
	wire qd_step = qd_now != qd_q;
	// forward when a leads b: old b differs from new a
	wire qd_fwd = qd_q[1] ^ qd_now[0];
	wire vel_tick = vel_div == 8'(VEL_PERIOD - 1);
	wire [15:0] next_pos = qd_fwd ? ((pos == buf3) ? 16'h0000 : pos + 16'h0001)
		: ((pos == 16'h0000) ? buf3 : pos - 16'h0001);
	logic [2:0] hw_set;

	// event detection per channel, with a divide-by-four prescaler in rise4 mode
	logic [2:0] ev_edge;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			unique case (mfsc_cap_mode_t'(ccon[i][3:0]))
				MFSC_CAP_RISE: ev_edge[i] = cap_in[i] & ~cap_q[i];
				MFSC_CAP_FALL: ev_edge[i] = ~cap_in[i] & cap_q[i];
				MFSC_CAP_EDGE: ev_edge[i] = cap_in[i] ^ cap_q[i];
				MFSC_CAP_RISE4: ev_edge[i] = cap_in[i] & ~cap_q[i];
				default: ev_edge[i] = 1'b0;
			endcase
			ev[i] = ev_edge[i] && !qdec_on &&
				(ccon[i][3:0] != MFSC_CAP_RISE4 || ps[i] == `MFSC_PS_MAX);
		end
	end

	always_comb begin
		hw_set = 3'b000;
		if (pwr != MFSC_WAKING && clk_en) begin
			hw_set = ev;
		end
		if (run && qdec_on && vel_tick) begin
			hw_set[0] = 1'b1;
		end
		if (run && qdec_on && qd_step) begin
			hw_set[1] = 1'b1;
		end
		if (run && qdec_on && qd_step && qd_fwd != dir) begin
			hw_set[2] = 1'b1;
		end
	end

	assign wake = pwr == MFSC_ASLEEP && |(hw_set & irq_en[3:1]);
	assign asleep = pwr == MFSC_ASLEEP;
	assign irq = |flag_hit;

	always_comb begin
		next_pwr = pwr;
		unique case (pwr)
			MFSC_AWAKE: if (sleep_req) next_pwr = MFSC_ASLEEP;
			MFSC_ASLEEP: if (wake) next_pwr = MFSC_WAKING;
			MFSC_WAKING: next_pwr = MFSC_AWAKE;
			default: next_pwr = MFSC_AWAKE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwr <= MFSC_AWAKE;
		end else if (clk_en) begin
			pwr <= next_pwr;
		end
	end

	// input history and prescalers; prescaler runs asleep too
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_q <= 3'b000;
			qd_q <= 2'b00;
			for (int i = 0; i < 3; i++) ps[i] <= 2'b00;
		end else if (clk_en) begin
			cap_q <= cap_in;
			if (run) qd_q <= qd_now;
			for (int i = 0; i < 3; i++) begin
				if (ev_edge[i] && ccon[i][3:0] == MFSC_CAP_RISE4) ps[i] <= ps[i] + 2'b01;
			end
		end
	end

	// flags: hardware set wins over software write-one-to-clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags <= `MFSC_RST_BYTE;
			pend <= 3'b000;
		end else if (clk_en) begin
			for (int i = 0; i < 3; i++) begin
				if (hw_set[i]) flags[i+1] <= 1'b1;
				else if (wr_flags && wdata[i+1]) flags[i+1] <= 1'b0;
				if (pwr == MFSC_ASLEEP && ev[i]) pend[i] <= 1'b1;
				else if (pwr == MFSC_WAKING) pend[i] <= 1'b0;
			end
		end
	end

	// timer, halted while asleep
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tmr <= `MFSC_RST_WORD;
		end else if (wr && addr == `MFSC_OFS_TMR_H) begin
			tmr[15:8] <= wdata;
		end else if (wr && addr == `MFSC_OFS_TMR_L) begin
			tmr[7:0] <= wdata;
		end else if (run && tmr_on) begin
			tmr <= (tmr == period) ? 16'h0000 : tmr + 16'h0001;
		end
	end

	// decoder state, frozen asleep
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pos <= `MFSC_RST_WORD;
			dir <= 1'b0;
			vel_cnt <= `MFSC_RST_WORD;
			vel_div <= `MFSC_RST_BYTE;
		end else if (wr && addr == `MFSC_OFS_BUF2_H) begin
			pos[15:8] <= wdata;
		end else if (wr && addr == `MFSC_OFS_BUF2_L) begin
			pos[7:0] <= wdata;
		end else if (run && qdec_on) begin
			vel_div <= vel_tick ? 8'h00 : vel_div + 8'h01;
			vel_cnt <= vel_tick ? 16'(qd_step) : vel_cnt + 16'(qd_step);
			if (qd_step) begin
				pos <= next_pos;
				dir <= qd_fwd;
			end
		end
	end

	// capture buffers; repurposed in decoder mode
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			buf1 <= `MFSC_RST_WORD;
			buf3 <= `MFSC_RST_PERIOD;
		end else if (clk_en) begin
			if (wr && addr == `MFSC_OFS_BUF1_H) buf1[15:8] <= wdata;
			else if (wr && addr == `MFSC_OFS_BUF1_L) buf1[7:0] <= wdata;
			else if (run && qdec_on && vel_tick) buf1 <= vel_cnt;
			else if ((pwr == MFSC_WAKING && pend[0]) || (run && ev[0])) buf1 <= tmr;
			if (wr && addr == `MFSC_OFS_BUF3_H) buf3[15:8] <= wdata;
			else if (wr && addr == `MFSC_OFS_BUF3_L) buf3[7:0] <= wdata;
			else if ((pwr == MFSC_WAKING && pend[2]) || (run && ev[2])) buf3 <= tmr;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			buf2 <= `MFSC_RST_WORD;
		end else if (clk_en) begin
			if (wr && addr == `MFSC_OFS_BUF2_H) buf2[15:8] <= wdata;
			else if (wr && addr == `MFSC_OFS_BUF2_L) buf2[7:0] <= wdata;
			else if ((pwr == MFSC_WAKING && pend[1]) || (run && ev[1])) buf2 <= tmr;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			period <= `MFSC_RST_PERIOD;
			tcon <= `MFSC_RST_BYTE;
			qcon <= `MFSC_RST_BYTE;
			irq_en <= `MFSC_RST_BYTE;
			for (int i = 0; i < 3; i++) ccon[i] <= `MFSC_RST_BYTE;
		end else if (wr) begin
			if (addr == `MFSC_OFS_PER_H) period[15:8] <= wdata;
			if (addr == `MFSC_OFS_PER_L) period[7:0] <= wdata;
			if (addr == `MFSC_OFS_TCON) tcon <= wdata;
			if (addr == `MFSC_OFS_QDEC_CON) qcon <= wdata;
			if (addr == `MFSC_OFS_IRQ_EN) irq_en <= wdata & `MFSC_IRQ_MASK;
			if (addr == `MFSC_OFS_CAP1_CON) ccon[0] <= wdata & 8'h4F;
			if (addr == `MFSC_OFS_CAP2_CON) ccon[1] <= wdata & 8'h4F;
			if (addr == `MFSC_OFS_CAP3_CON) ccon[2] <= wdata & 8'h4F;
		end
	end

	// position visible through channel 2 bytes
	wire [15:0] rd_buf2 = qdec_on ? pos : buf2;
	logic [7:0] rmux;
	always_comb begin
		unique case (addr)
			`MFSC_OFS_TMR_H: rmux = tmr[15:8];
			`MFSC_OFS_TMR_L: rmux = tmr[7:0];
			`MFSC_OFS_PER_H: rmux = period[15:8];
			`MFSC_OFS_PER_L: rmux = period[7:0];
			`MFSC_OFS_TCON: rmux = tcon;
			`MFSC_OFS_BUF1_H: rmux = buf1[15:8];
			`MFSC_OFS_BUF1_L: rmux = buf1[7:0];
			`MFSC_OFS_BUF2_H: rmux = rd_buf2[15:8];
			`MFSC_OFS_BUF2_L: rmux = rd_buf2[7:0];
			`MFSC_OFS_BUF3_H: rmux = buf3[15:8];
			`MFSC_OFS_BUF3_L: rmux = buf3[7:0];
			`MFSC_OFS_CAP1_CON: rmux = ccon[0];
			`MFSC_OFS_CAP2_CON: rmux = ccon[1];
			`MFSC_OFS_CAP3_CON: rmux = ccon[2];
			`MFSC_OFS_QDEC_CON: rmux = {qcon[7:6], dir, qcon[4:0]};
			`MFSC_OFS_IRQ_FLAGS: rmux = flags;
			`MFSC_OFS_IRQ_EN: rmux = irq_en;
			`MFSC_OFS_SLEEP: rmux = {6'h00, pwr};
			default: rmux = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) rdata <= 8'h00;
		else if (rd) rdata <= rmux;
		else rdata <= 8'h00;
	end

	a_tmr_frozen: assert property (@(posedge clk) disable iff (!rst_n)
		pwr == MFSC_ASLEEP && !wr |=> tmr == $past(tmr)) else $error("timer moved asleep");
	a_sleep_flag: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && pwr == MFSC_ASLEEP && ev[0] |=> flags[1]) else $error("flag missing");
	a_wake_load: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && pwr == MFSC_WAKING && pend[1] && !wr |=> buf2 == $past(tmr))
		else $error("buffer not loaded on wake");
	a_wake_exit: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wake |=> pwr == MFSC_WAKING) else $error("no wake");
	a_pos_frozen: assert property (@(posedge clk) disable iff (!rst_n)
		pwr == MFSC_ASLEEP && !wr |=> pos == $past(pos) && dir == $past(dir))
		else $error("decoder moved asleep");
	a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
		irq == |(flags & irq_en)) else $error("irq mismatch");
	a_pos_flag: assert property (@(posedge clk) disable iff (!rst_n)
		run && qdec_on && qd_step |=> flags[2]) else $error("position flag");
	a_dir_flag: assert property (@(posedge clk) disable iff (!rst_n)
		run && qdec_on && qd_step && qd_fwd != dir |=> flags[3]) else $error("dir flag");
	a_vel_flag: assert property (@(posedge clk) disable iff (!rst_n)
		run && qdec_on && vel_tick |=> flags[1] && buf1 == $past(vel_cnt))
		else $error("velocity");
	c_sleep_wake: cover property (@(posedge clk) pwr == MFSC_ASLEEP ##1 pwr == MFSC_WAKING);
	c_qdec_step: cover property (@(posedge clk) run && qdec_on && qd_step);
	c_capture: cover property (@(posedge clk) run && ev[0]);
	c_prescale_wrap: cover property (@(posedge clk) pwr == MFSC_ASLEEP && ev[1]);
	c_dir_change: cover property (@(posedge clk) run && qdec_on && qd_step && qd_fwd != dir);

	// sleep side: prescalers, buffers and wake bookkeeping; then flag set-wins and clear
	a_ps_counts: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && pwr == MFSC_ASLEEP && ev_edge[1] && ccon[1][3:0] == MFSC_CAP_RISE4
		|=> ps[1] == $past(ps[1]) + 2'b01)
		else $error("prescaler stalled asleep");

	a_sleep_noload: assert property (@(posedge clk) disable iff (!rst_n)
		pwr == MFSC_ASLEEP && !wr
		|=> buf1 == $past(buf1) && buf2 == $past(buf2) && buf3 == $past(buf3))
		else $error("buffer loaded asleep");

	a_wake_pend_set: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && pwr == MFSC_ASLEEP && ev[1]
		|=> pend[1])
		else $error("sleep event not remembered");

	a_wake_load1: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && pwr == MFSC_WAKING && pend[0] && !wr
		|=> buf1 == $past(tmr))
		else $error("channel 1 not loaded on wake");

	a_wake_load3: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && pwr == MFSC_WAKING && pend[2] && !wr
		|=> buf3 == $past(tmr))
		else $error("channel 3 not loaded on wake");

	a_irq_wake: assert property (@(posedge clk) disable iff (!rst_n)
		pwr == MFSC_ASLEEP && hw_set[1] && irq_en[2]
		|-> wake)
		else $error("enabled event did not wake");

	a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && hw_set[2] && wr_flags && wdata[3]
		|=> flags[3])
		else $error("clear beat hardware set");

	a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wr_flags && wdata[1] && !hw_set[0]
		|=> !flags[1])
		else $error("flag not cleared");

	// decoder side
	a_vel_frozen: assert property (@(posedge clk) disable iff (!rst_n)
		pwr == MFSC_ASLEEP
		|=> vel_cnt == $past(vel_cnt) && vel_div == $past(vel_div))
		else $error("velocity moved asleep");

	a_qdec_noflag: assert property (@(posedge clk) disable iff (!rst_n)
		pwr == MFSC_ASLEEP && qdec_on && !wr_flags
		|=> flags == $past(flags))
		else $error("decoder flag asleep");

	a_no_wake_qdec: assert property (@(posedge clk) disable iff (!rst_n)
		qdec_on
		|-> !wake)
		else $error("decoder woke device");

	a_pos_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		run && qdec_on && qd_step && qd_fwd && pos == buf3 && !wr
		|=> pos == 16'h0000)
		else $error("position did not wrap");

	a_limit_rev: assert property (@(posedge clk) disable iff (!rst_n)
		run && qdec_on && qd_step && !qd_fwd && pos == 16'h0000 && !wr
		|=> pos == $past(buf3))
		else $error("position did not reload limit");

	a_pos_read: assert property (@(posedge clk) disable iff (!rst_n)
		rd && addr == `MFSC_OFS_BUF2_L && qdec_on
		|=> rdata == $past(pos[7:0]))
		else $error("position low byte read");

	a_dir_track: assert property (@(posedge clk) disable iff (!rst_n)
		run && qdec_on && qd_step && !wr
		|=> dir == $past(qd_fwd))
		else $error("direction not tracked");

	a_vel_clear: assert property (@(posedge clk) disable iff (!rst_n)
		run && qdec_on && vel_tick && !wr
		|=> vel_cnt == {15'h0000, $past(qd_step)})
		else $error("velocity window not restarted");
endmodule

// ===== tb/mfsc_partner.sv
`timescale 1ns/1ns
module mfsc_partner (
	input wire logic clk,
	output logic [2:0] cap_in
);
	int phase;
	initial begin
		cap_in = 3'b000;
		phase = 0;
	end
	// each level held two cycles so the edge detector cannot miss it
	task automatic pulse(input int ch);
		repeat (2) @(posedge clk);
		cap_in[ch] <= 1'b1;
		repeat (2) @(posedge clk);
		cap_in[ch] <= 1'b0;
	endtask
	// gray code on a and b, a leads b when moving forward
	task automatic steps(input bit fwd, input int n);
		repeat (n) begin
			repeat (2) @(posedge clk);
			phase = fwd ? (phase + 1) % 4 : (phase + 3) % 4;
			cap_in[1] <= (phase == 1) || (phase == 2);
			cap_in[2] <= (phase >= 2);
		end
	endtask
endmodule

// ===== tb/motion_feedback_sleep_capture_tb.sv
`timescale 1ns/1ns
`include "mfsc_params.svh"
module motion_feedback_sleep_capture_tb;
	import mfsc_pkg::*;
	logic clk, rst_n, clk_en, wr, rd, sleep_req, asleep, wake, irq, rd_q;
	logic [7:0] addr, wdata, rdata;
	logic [2:0] cap_in;
	logic [7:0] exp_q[$];
	logic [15:0] tval;
	int err_count, comparisons, seed;
	mfsc_core #(.VEL_PERIOD(8)) uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cap_in(cap_in),
		.sleep_req(sleep_req), .asleep(asleep), .wake(wake), .irq(irq));
	mfsc_partner enc (.clk(clk), .cap_in(cap_in));
	always #10 clk = ~clk;
	task automatic conclude();
		if (err_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic fail(input string msg);
		err_count++;
		$display("CHECK FAILED %0t %s", $time, msg);
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string msg);
		comparisons++;
		if (got !== exp) fail(msg);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// sleep_req is a level, dropped once asleep so a wake-up is not undone
	task automatic go_sleep();
		@(posedge clk);
		sleep_req <= 1'b1;
		repeat (2) @(posedge clk);
		sleep_req <= 1'b0;
		chk_bit(asleep, 1'b1, "not asleep");
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_q <= rd;
		if (rd_q) begin
			comparisons++;
			if (exp_q.size() == 0)
				fail("unexpected read");
			else if (rdata !== exp_q.pop_front())
				fail("read data");
		end
	end
	initial begin
		#400000;
		fail("timeout");
		conclude();
	end
	initial begin
		clk = 0;
		rst_n = 0;
		clk_en = 1;
		wr = 0;
		rd = 0;
		rd_q = 0;
		addr = 0;
		wdata = 0;
		sleep_req = 0;
		seed = 32'h5c7e;
		err_count = 0;
		comparisons = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rreg(`MFSC_OFS_PER_H, 8'hff);
		rreg(`MFSC_OFS_BUF3_L, 8'hff);
		rreg(`MFSC_OFS_IRQ_FLAGS, 8'h00);
		rreg(8'h3f, 8'h00);
		tval = 16'($random(seed));
		wreg(`MFSC_OFS_PER_L, tval[7:0]);
		rreg(`MFSC_OFS_PER_L, tval[7:0]);
		wreg(`MFSC_OFS_CAP1_CON, {4'h0, MFSC_CAP_RISE});
		wreg(`MFSC_OFS_IRQ_EN, 8'h02);
		enc.pulse(0);
		tick(4);
		chk_bit(irq, 1'b1, "capture irq");
		wreg(`MFSC_OFS_IRQ_FLAGS, 8'h02);
		tick(1);
		chk_bit(irq, 1'b0, "irq after clear");
		// timer left off so its count is fixed across the sleep
		wreg(`MFSC_OFS_TMR_H, tval[15:8]);
		wreg(`MFSC_OFS_TMR_L, tval[7:0]);
		wreg(`MFSC_OFS_CAP2_CON, {4'h0, MFSC_CAP_RISE4});
		wreg(`MFSC_OFS_CAP3_CON, {4'h0, MFSC_CAP_RISE});
		wreg(`MFSC_OFS_IRQ_EN, 8'h04);
		go_sleep();
		rreg(`MFSC_OFS_SLEEP, 8'h01);
		enc.pulse(2);
		tick(4);
		chk_bit(asleep, 1'b1, "masked event woke");
		rreg(`MFSC_OFS_IRQ_FLAGS, 8'h08);
		rreg(`MFSC_OFS_BUF3_H, 8'hff);
		rreg(`MFSC_OFS_BUF3_L, 8'hff);
		repeat (3) enc.pulse(1);
		tick(4);
		chk_bit(asleep, 1'b1, "woke before fourth edge");
		enc.pulse(1);
		tick(4);
		chk_bit(asleep, 1'b0, "no wake");
		rreg(`MFSC_OFS_BUF2_H, tval[15:8]);
		rreg(`MFSC_OFS_BUF2_L, tval[7:0]);
		rreg(`MFSC_OFS_IRQ_FLAGS, 8'h0c);
		wreg(`MFSC_OFS_CAP2_CON, 8'h00);
		wreg(`MFSC_OFS_CAP3_CON, 8'h00);
		wreg(`MFSC_OFS_IRQ_EN, 8'h0e);
		wreg(`MFSC_OFS_IRQ_FLAGS, 8'h0e);
		wreg(`MFSC_OFS_QDEC_CON, 8'h04);
		wreg(`MFSC_OFS_BUF3_H, 8'hff);
		wreg(`MFSC_OFS_BUF3_L, 8'hff);
		wreg(`MFSC_OFS_BUF2_H, 8'h00);
		wreg(`MFSC_OFS_BUF2_L, 8'h10);
		rreg(`MFSC_OFS_BUF2_H, 8'h00);
		rreg(`MFSC_OFS_BUF2_L, 8'h10);
		rreg(`MFSC_OFS_BUF3_L, 8'hff);
		// clock enable low: a round trip of steps must leave position untouched
		@(posedge clk);
		clk_en <= 1'b0;
		enc.steps(1'b1, 3);
		enc.steps(1'b0, 3);
		rreg(`MFSC_OFS_BUF2_L, 8'h10);
		@(posedge clk);
		clk_en <= 1'b1;
		enc.steps(1'b1, 6);
		enc.steps(1'b0, 6);
		tick(20);
		rreg(`MFSC_OFS_BUF2_L, 8'h10);
		rreg(`MFSC_OFS_IRQ_FLAGS, 8'h0e);
		chk_bit(irq, 1'b1, "decoder irq");
		// asleep the decoder is frozen: steps leave position and flags untouched
		go_sleep();
		wreg(`MFSC_OFS_IRQ_FLAGS, 8'h0e);
		enc.steps(1'b1, 8);
		enc.steps(1'b0, 3);
		tick(20);
		rreg(`MFSC_OFS_BUF2_L, 8'h10);
		rreg(`MFSC_OFS_IRQ_FLAGS, 8'h00);
		tick(3);
		conclude();
	end
endmodule
